// ### sfpu_defs.vh
// constants shared by the single precision floating point unit
`ifndef SFPU_DEFS_VH
`define SFPU_DEFS_VH

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define SFPU_OP_ADD 4'h0
`define SFPU_OP_SUB 4'h1
`define SFPU_OP_MUL 4'h2
`define SFPU_OP_DIV 4'h3
`define SFPU_OP_LT 4'h8
`define SFPU_OP_EQ 4'h9
`define SFPU_OP_LE 4'ha
`define SFPU_OP_GT 4'hb
`define SFPU_OP_NE 4'hc
`define SFPU_OP_GE 4'hd
`define SFPU_OP_UN 4'he
`define SFPU_OP_CMP_BIT 3

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SFPU_REG_CTRL 12'h000
`define SFPU_REG_STATUS 12'h004
`define SFPU_REG_RESULT 12'h008
`define SFPU_CTRL_RST 5'h00
`define SFPU_STATUS_RST 5'h00
`define SFPU_BUSY_BIT 8

// ----------------------------------------------------------------
// status flag positions
// ----------------------------------------------------------------
`define SFPU_FL_UF 0
`define SFPU_FL_OF 1
`define SFPU_FL_INV 2
`define SFPU_FL_DZ 3
`define SFPU_FL_DEN 4
`define SFPU_FL_W 5

// ----------------------------------------------------------------
// number format
// ----------------------------------------------------------------
`define SFPU_SIGN 31
`define SFPU_EXP_HI 30
`define SFPU_EXP_LO 23
`define SFPU_FRAC_HI 22
`define SFPU_QUIET_BIT 22
`define SFPU_EXP_ONES 8'hff
`define SFPU_EXP_OVF 12'h0ff
`define SFPU_BIAS 12'h07f
`define SFPU_DIV_BIAS 12'h07e
`define SFPU_QNAN 32'hffc00000
`define SFPU_TRUE 32'h00000001
`define SFPU_FALSE 32'h00000000

// ----------------------------------------------------------------
// working mantissa
// ----------------------------------------------------------------
`define SFPU_MSB 49
`define SFPU_MSB_POS 6'h31
`define SFPU_LEAD 12'h030
`define SFPU_GUARD 25
`define SFPU_ALIGN_MAX 8'h19
`define SFPU_DIV_STEPS 5'h1b

`endif

// ### sfpu_div.v
// iterative restoring divider for significands
`default_nettype none
`include "sfpu_defs.vh"

module sfpu_div (
  // clock and reset
  input wire pclk,
  input wire presetn,
  input wire ce,
  // request
  input wire start,
  input wire [23:0] dividend,
  input wire [23:0] divisor,
  // answer
  output reg done,
  output reg [26:0] quot,
  output wire sticky
);

  reg [24:0] rem;
  reg [4:0] cnt;
  reg run;

  assign sticky = (rem != 25'h0000000);

  // ----------------------------------------------------------------
  // one quotient bit per cycle
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem <= 25'h0000000;
      cnt <= 5'h00;
      run <= 1'b0;
      done <= 1'b0;
      quot <= 27'h0000000;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        rem <= {1'b0, dividend};
        cnt <= `SFPU_DIV_STEPS;
        run <= 1'b1;
        quot <= 27'h0000000;
      end else if (run) begin
        if (rem >= {1'b0, divisor}) begin
          rem <= {rem[23:0] - divisor, 1'b0};
          quot <= {quot[25:0], 1'b1};
        end else begin
          rem <= {rem[23:0], 1'b0};
          quot <= {quot[25:0], 1'b0};
        end
        cnt <= cnt - 5'h01;
        if (cnt == 5'h01) begin
          run <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule // sfpu_div
`default_nettype wire

// ### sfpu_pipe_model.sv
// pipeline model: general registers, issue and write back
`default_nettype none

module sfpu_pipe_model (
  // clock
  input wire logic pclk,
  // issue
  output logic issue_valid,
  output logic [3:0] issue_op,
  output logic [4:0] issue_rd,
  output logic [31:0] issue_ra,
  output logic [31:0] issue_rb,
  input wire logic issue_ready,
  // answer
  input wire logic wb_valid,
  input wire logic [4:0] wb_rd,
  input wire logic [31:0] wb_data,
  input wire logic exc_valid,
  input wire logic [4:0] exc_cause
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] gpr [0:31];
  logic [4:0] cause;
  logic late;

  initial begin
    issue_valid = 1'b0;
    issue_op = 4'h0;
    issue_rd = 5'h00;
    issue_ra = 32'h0;
    issue_rb = 32'h0;
    late = 1'b0;
  end

  // write back only on a pulse, never on an exception
  always @(posedge pclk) begin
    if (wb_valid === 1'b1) begin
      gpr[wb_rd] <= wb_data;
    end
  end

  // issue one op from registers and wait for its answer
  task automatic exec(input logic [3:0] op, input logic [4:0] ra, rb, rd);
    int n;
    logic miss;
    @(posedge pclk);
    issue_valid <= 1'b1;
    issue_op <= op;
    issue_rd <= rd;
    issue_ra <= gpr[ra];
    issue_rb <= gpr[rb];
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (issue_ready !== 1'b1 && n < 50);
    miss = (issue_ready !== 1'b1);
    issue_valid <= 1'b0;
    issue_ra <= ~issue_ra;
    issue_rb <= ~issue_rb;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (wb_valid !== 1'b1 && exc_valid !== 1'b1 && n < 60);
    cause = (exc_valid === 1'b1) ? exc_cause : 5'h00;
    late = miss || (wb_valid !== 1'b1 && exc_valid !== 1'b1);
  endtask
endmodule // sfpu_pipe_model
`default_nettype wire

// ### sfpu_round.v
// normalise, round to nearest even and pack a working mantissa
`default_nettype none
`include "sfpu_defs.vh"

module sfpu_round (
  // unpacked value
  input wire sign,
  input wire [11:0] exp_in,
  input wire [`SFPU_MSB:0] mant,
  // packed result
  output reg [31:0] result,
  output reg overflow,
  output reg underflow
);

  // ----------------------------------------------------------------
  // leading one search
  // ----------------------------------------------------------------
  function [5:0] sfpu_lead;
    input [`SFPU_MSB:0] v;
    integer i;
    begin
      sfpu_lead = 6'h00;
      for (i = 0; i <= `SFPU_MSB; i = i + 1) begin
        if (v[i]) begin
          sfpu_lead = i[5:0];
        end
      end
    end
  endfunction

  reg [5:0] pos;
  reg [`SFPU_MSB:0] norm;
  reg [11:0] exp_n;
  reg rnd;
  reg [24:0] sig;

  // ----------------------------------------------------------------
  // normalise and round
  // ----------------------------------------------------------------
  always @* begin
    pos = sfpu_lead(mant);
    norm = mant << (`SFPU_MSB_POS - pos);
    exp_n = exp_in + {6'h00, pos} - `SFPU_LEAD;
    rnd = norm[`SFPU_GUARD] & (norm[`SFPU_GUARD+1] | (|norm[`SFPU_GUARD-1:0]));
    sig = {2'b01, norm[`SFPU_MSB-1:`SFPU_GUARD+1]} + {24'h000000, rnd};
    if (sig[24]) begin
      exp_n = exp_n + 12'h001;
    end
    overflow = 1'b0;
    underflow = 1'b0;
    if (mant == {(`SFPU_MSB+1){1'b0}}) begin
      result = {sign, 31'h00000000};
    end else if (!exp_n[11] && exp_n >= `SFPU_EXP_OVF) begin
      overflow = 1'b1;
      result = {sign, `SFPU_EXP_ONES, 23'h000000};
    end else if (exp_n[11] || exp_n == 12'h000) begin
      underflow = 1'b1;
      result = {sign, 31'h00000000};
    end else begin
      result = {sign, exp_n[7:0], sig[22:0]};
    end
  end

endmodule // sfpu_round
`default_nettype wire

// ### sfpu_top.v
// single precision floating point execution unit with apb status access
`default_nettype none
`include "sfpu_defs.vh"

module sfpu_top (
  // clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // issue from the pipeline
  input wire issue_valid,
  input wire [3:0] issue_op,
  input wire [4:0] issue_rd,
  input wire [31:0] issue_ra,
  input wire [31:0] issue_rb,
  output wire issue_ready,
  // write back to the general registers
  output reg wb_valid,
  output reg [4:0] wb_rd,
  output reg [31:0] wb_data,
  // hardware exception
  output reg exc_valid,
  output reg [`SFPU_FL_W-1:0] exc_cause
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_CALC = 3'b010;
  localparam ST_DIV = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [3:0] op;
  reg [4:0] rd;
  reg [31:0] opa;
  reg [31:0] opb;
  reg [`SFPU_FL_W-1:0] exc_en;
  reg [`SFPU_FL_W-1:0] fp_status_reg;
  reg [31:0] last_result;

  // ----------------------------------------------------------------
  // operand fields and classes
  // ----------------------------------------------------------------
  wire sa = opa[`SFPU_SIGN];
  wire sb = opb[`SFPU_SIGN];
  wire [7:0] ea = opa[`SFPU_EXP_HI:`SFPU_EXP_LO];
  wire [7:0] eb = opb[`SFPU_EXP_HI:`SFPU_EXP_LO];
  wire [22:0] fa = opa[`SFPU_FRAC_HI:0];
  wire [22:0] fb = opb[`SFPU_FRAC_HI:0];
  wire a_nan = (ea == `SFPU_EXP_ONES) && (fa != 23'h000000);
  wire b_nan = (eb == `SFPU_EXP_ONES) && (fb != 23'h000000);
  wire a_inf = (ea == `SFPU_EXP_ONES) && (fa == 23'h000000);
  wire b_inf = (eb == `SFPU_EXP_ONES) && (fb == 23'h000000);
  wire a_zero = (ea == 8'h00) && (fa == 23'h000000);
  wire b_zero = (eb == 8'h00) && (fb == 23'h000000);
  wire a_den = (ea == 8'h00) && (fa != 23'h000000);
  wire b_den = (eb == 8'h00) && (fb != 23'h000000);
  wire any_snan = (a_nan && !fa[`SFPU_QUIET_BIT]) || (b_nan && !fb[`SFPU_QUIET_BIT]);
  wire [23:0] ma = {ea != 8'h00, fa};
  wire [23:0] mb = {eb != 8'h00, fb};
  wire is_cmp = op[`SFPU_OP_CMP_BIT];
  wire sbe = sb ^ (op == `SFPU_OP_SUB);
  wire sx = sa ^ sb;

  // ----------------------------------------------------------------
  // magnitude comparison, used by the adder and the comparisons
  // ----------------------------------------------------------------
  function sfpu_mag_lt;
    input [30:0] x;
    input [30:0] y;
    begin
      sfpu_mag_lt = (x < y);
    end
  endfunction

  // ----------------------------------------------------------------
  // adder alignment
  // ----------------------------------------------------------------
  wire swap = sfpu_mag_lt(opa[30:0], opb[30:0]);
  wire [7:0] e_big = swap ? eb : ea;
  wire [7:0] e_small = swap ? ea : eb;
  wire [23:0] m_big = swap ? mb : ma;
  wire [23:0] m_small = swap ? ma : mb;
  wire s_big = swap ? sbe : sa;
  wire [7:0] e_diff = e_big - e_small;
  wire [`SFPU_MSB:0] w_big = {1'b0, m_big, 25'h0000000};
  wire [`SFPU_MSB:0] w_small_full = {1'b0, m_small, 25'h0000000};
  reg [`SFPU_MSB:0] w_small;
  reg [`SFPU_MSB:0] w_sum;

  always @* begin
    if (e_diff > `SFPU_ALIGN_MAX) begin
      w_small = {{`SFPU_MSB{1'b0}}, m_small != 24'h000000};
    end else begin
      w_small = w_small_full >> e_diff;
    end
    if (sa == sbe) begin
      w_sum = w_big + w_small;
    end else begin
      w_sum = w_big - w_small;
    end
  end

  // ----------------------------------------------------------------
  // multiplier and divider
  // ----------------------------------------------------------------
  wire [47:0] prod = ma * mb;
  wire div_done;
  wire [26:0] div_quot;
  wire div_sticky;
  reg div_start;

  sfpu_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(div_start),
    .dividend(ma),
    .divisor(mb),
    .done(div_done),
    .quot(div_quot),
    .sticky(div_sticky)
  );

  // ----------------------------------------------------------------
  // datapath select and rounding
  // ----------------------------------------------------------------
  reg r_sign;
  reg [11:0] r_exp;
  reg [`SFPU_MSB:0] r_mant;
  wire [31:0] rnd_result;
  wire rnd_of;
  wire rnd_uf;

  always @* begin
    case (op)
      `SFPU_OP_MUL: begin
        r_sign = sx;
        r_exp = {4'h0, ea} + {4'h0, eb} - `SFPU_BIAS;
        r_mant = {prod, 2'b00};
      end
      `SFPU_OP_DIV: begin
        r_sign = sx;
        r_exp = {4'h0, ea} - {4'h0, eb} + `SFPU_DIV_BIAS;
        r_mant = {div_quot, div_sticky, 22'h000000};
      end
      default: begin
        r_sign = (w_sum == {(`SFPU_MSB+1){1'b0}}) ? (sa & sbe) : s_big;
        r_exp = {4'h0, e_big};
        r_mant = w_sum;
      end
    endcase
  end

  sfpu_round u_round (
    .sign(r_sign),
    .exp_in(r_exp),
    .mant(r_mant),
    .result(rnd_result),
    .overflow(rnd_of),
    .underflow(rnd_uf)
  );

  // ----------------------------------------------------------------
  // comparisons
  // ----------------------------------------------------------------
  wire any_nan = a_nan || b_nan;
  wire both_zero = a_zero && b_zero;
  wire c_eq = (opa == opb) || both_zero;
  wire c_lt = !both_zero && ((sa != sb) ? sa :
              (sa ? sfpu_mag_lt(opb[30:0], opa[30:0]) : sfpu_mag_lt(opa[30:0], opb[30:0])));
  reg c_true;

  always @* begin
    case (op)
      `SFPU_OP_LT: c_true = !any_nan && c_lt;
      `SFPU_OP_EQ: c_true = !any_nan && c_eq;
      `SFPU_OP_LE: c_true = !any_nan && (c_lt || c_eq);
      `SFPU_OP_GT: c_true = !any_nan && !c_lt && !c_eq;
      `SFPU_OP_NE: c_true = !any_nan && !c_eq;
      `SFPU_OP_GE: c_true = !any_nan && !c_lt;
      `SFPU_OP_UN: c_true = any_nan;
      default: c_true = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // special operands and final result
  // ----------------------------------------------------------------
  reg spec;
  reg [31:0] res;
  reg [`SFPU_FL_W-1:0] fl;

  always @* begin
    spec = 1'b1;
    res = `SFPU_QNAN;
    fl = {`SFPU_FL_W{1'b0}};
    if (a_den || b_den) begin
      fl[`SFPU_FL_DEN] = 1'b1;
      res = is_cmp ? `SFPU_FALSE : `SFPU_QNAN;
    end else if (is_cmp) begin
      fl[`SFPU_FL_INV] = any_snan;
      res = c_true ? `SFPU_TRUE : `SFPU_FALSE;
    end else if (any_nan) begin
      fl[`SFPU_FL_INV] = any_snan;
      res = `SFPU_QNAN;
    end else begin
      case (op)
        `SFPU_OP_MUL: begin
          if ((a_inf && b_zero) || (a_zero && b_inf)) begin
            fl[`SFPU_FL_INV] = 1'b1;
          end else if (a_inf || b_inf) begin
            res = {sx, `SFPU_EXP_ONES, 23'h000000};
          end else begin
            spec = 1'b0;
          end
        end
        `SFPU_OP_DIV: begin
          if ((a_zero && b_zero) || (a_inf && b_inf)) begin
            fl[`SFPU_FL_INV] = 1'b1;
          end else if (a_inf) begin
            res = {sx, `SFPU_EXP_ONES, 23'h000000};
          end else if (b_zero) begin
            fl[`SFPU_FL_DZ] = 1'b1;
            res = {sx, `SFPU_EXP_ONES, 23'h000000};
          end else if (b_inf) begin
            res = {sx, 31'h00000000};
          end else begin
            spec = 1'b0;
          end
        end
        default: begin
          if (a_inf && b_inf && (sa != sbe)) begin
            fl[`SFPU_FL_INV] = 1'b1;
          end else if (a_inf) begin
            res = {sa, `SFPU_EXP_ONES, 23'h000000};
          end else if (b_inf) begin
            res = {sbe, `SFPU_EXP_ONES, 23'h000000};
          end else begin
            spec = 1'b0;
          end
        end
      endcase
    end
    if (!spec) begin
      res = rnd_result;
      fl[`SFPU_FL_OF] = rnd_of;
      fl[`SFPU_FL_UF] = rnd_uf;
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  wire finish = ((state == ST_CALC) && !(op == `SFPU_OP_DIV && !spec)) ||
                ((state == ST_DIV) && div_done);
  wire [`SFPU_FL_W-1:0] trap = fl & exc_en;

  assign issue_ready = ce && (state == ST_IDLE);

  always @* begin
    next_state = state;
    div_start = 1'b0;
    case (state)
      ST_IDLE: begin
        if (issue_valid) begin
          next_state = ST_CALC;
        end
      end
      ST_CALC: begin
        if (op == `SFPU_OP_DIV && !spec) begin
          div_start = 1'b1;
          next_state = ST_DIV;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_DIV: begin
        if (div_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      op <= `SFPU_OP_ADD;
      rd <= 5'h00;
      opa <= 32'h00000000;
      opb <= 32'h00000000;
      wb_valid <= 1'b0;
      wb_rd <= 5'h00;
      wb_data <= 32'h00000000;
      exc_valid <= 1'b0;
      exc_cause <= {`SFPU_FL_W{1'b0}};
      last_result <= 32'h00000000;
    end else if (ce) begin
      state <= next_state;
      wb_valid <= 1'b0;
      exc_valid <= 1'b0;
      if (state == ST_IDLE && issue_valid) begin
        op <= issue_op;
        rd <= issue_rd;
        opa <= issue_ra;
        opb <= issue_rb;
      end
      if (finish) begin
        last_result <= res;
        wb_rd <= rd;
        wb_data <= res;
        wb_valid <= (trap == {`SFPU_FL_W{1'b0}});
        exc_valid <= (trap != {`SFPU_FL_W{1'b0}});
        exc_cause <= trap;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  wire apb_wr = psel && penable && pwrite && ce;
  wire hit_ctrl = (paddr == `SFPU_REG_CTRL);
  wire hit_status = (paddr == `SFPU_REG_STATUS);
  wire hit_result = (paddr == `SFPU_REG_RESULT);
  wire [`SFPU_FL_W-1:0] st_set = finish ? fl : {`SFPU_FL_W{1'b0}};
  wire [`SFPU_FL_W-1:0] st_clr = (apb_wr && hit_status) ?
                                 pwdata[`SFPU_FL_W-1:0] : {`SFPU_FL_W{1'b0}};
  reg [31:0] rd_mux;

  assign pready = ce;
  assign pslverr = psel && penable && !(hit_ctrl || hit_status || hit_result);

  always @* begin
    rd_mux = 32'h00000000;
    if (hit_ctrl) begin
      rd_mux[`SFPU_FL_W-1:0] = exc_en;
    end else if (hit_status) begin
      rd_mux[`SFPU_FL_W-1:0] = fp_status_reg;
      rd_mux[`SFPU_BUSY_BIT] = (state != ST_IDLE);
    end else if (hit_result) begin
      rd_mux = last_result;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_en <= `SFPU_CTRL_RST;
      fp_status_reg <= `SFPU_STATUS_RST;
      prdata <= 32'h00000000;
    end else if (ce) begin
      if (psel && !penable) begin
        prdata <= rd_mux;
      end
      if (apb_wr && hit_ctrl) begin
        exc_en <= pwdata[`SFPU_FL_W-1:0];
      end
      fp_status_reg <= (fp_status_reg & ~st_clr) | st_set;
    end
  end

endmodule // sfpu_top
`default_nettype wire

// ### sfpu_top_sva.sv
// concurrent checks on the ports of the floating point unit
`default_nettype none
`include "sfpu_defs.vh"

module sfpu_top_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // issue
  input wire logic issue_valid,
  input wire logic [3:0] issue_op,
  input wire logic [31:0] issue_ra,
  input wire logic [31:0] issue_rb,
  input wire logic issue_ready,
  // answer
  input wire logic wb_valid,
  input wire logic [31:0] wb_data,
  input wire logic exc_valid,
  input wire logic [`SFPU_FL_W-1:0] exc_cause
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dclk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // helper state for the op in flight
  // ----------------------------------------------------------------
  logic take;
  logic last_cmp;
  logic last_nan;
  assign take = issue_valid && issue_ready;

  function automatic logic is_nan(input logic [31:0] v);
    return v[30:23] == 8'hff && v[22:0] != 23'h0;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cmp <= 1'b0;
      last_nan <= 1'b0;
    end else if (take) begin
      last_cmp <= issue_op[`SFPU_OP_CMP_BIT];
      last_nan <= !issue_op[`SFPU_OP_CMP_BIT] && (is_nan(issue_ra) || is_nan(issue_rb));
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_pulse_excl: assert property (!(wb_valid && exc_valid))
    else $error("write back and exception in one cycle");
  chk_wb_single: assert property (wb_valid |=> !wb_valid)
    else $error("write back pulse too long");
  chk_exc_single: assert property (exc_valid |=> !exc_valid)
    else $error("exception pulse too long");
  chk_exc_cause: assert property (exc_valid |-> exc_cause != 5'h00)
    else $error("exception without cause");
  chk_op_latency: assert property (take && issue_op != `SFPU_OP_DIV
    |-> ##[2:3] (wb_valid || exc_valid)) else $error("op answer late");
  chk_div_latency: assert property (take && issue_op == `SFPU_OP_DIV
    |-> ##[2:31] (wb_valid || exc_valid)) else $error("divide answer late");
  chk_busy_refuse: assert property (take |=> !issue_ready)
    else $error("ready while busy");
  chk_ready_back: assert property ((wb_valid || exc_valid) && ce |-> issue_ready)
    else $error("not ready after answer");
  chk_cmp_bool: assert property (wb_valid && last_cmp |-> wb_data[31:1] == 31'h0)
    else $error("compare result not boolean");
  chk_nan_canon: assert property (wb_valid && last_nan |-> wb_data == `SFPU_QNAN)
    else $error("nan result not canonical");

  cover property (wb_valid && last_cmp);
  cover property (exc_valid);
  cover property (take && issue_op == `SFPU_OP_DIV);
endmodule // sfpu_top_sva

bind sfpu_top sfpu_top_sva chk (.pclk, .presetn, .ce, .issue_valid, .issue_op, .issue_ra,
  .issue_rb, .issue_ready, .wb_valid, .wb_data, .exc_valid, .exc_cause);
`default_nettype wire

// ### tb_single_precision_fpu.sv
// self-checking testbench for the floating point unit
`default_nettype none
`include "sfpu_defs.vh"

module tb_single_precision_fpu;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, ce, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd_v;
  logic err_v;
  wire [31:0] prdata, issue_ra, issue_rb, wb_data;
  wire pready, pslverr, issue_valid, issue_ready, wb_valid, exc_valid;
  wire [3:0] issue_op;
  wire [4:0] issue_rd, wb_rd, exc_cause;
  int fails = 0;
  int n_checks = 0;

  sfpu_top uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .issue_valid, .issue_op, .issue_rd, .issue_ra, .issue_rb,
    .issue_ready, .wb_valid, .wb_rd, .wb_data, .exc_valid, .exc_cause);
  sfpu_pipe_model pm (.pclk, .issue_valid, .issue_op, .issue_rd, .issue_ra, .issue_rb,
    .issue_ready, .wb_valid, .wb_rd, .wb_data, .exc_valid, .exc_cause);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_op(input logic [3:0] op, input logic [31:0] a, b, exp,
                        input logic [4:0] cause);
    pm.gpr[1] = a;
    pm.gpr[2] = b;
    pm.gpr[3] = 32'h5a5a5a5a;
    pm.exec(op, 5'h01, 5'h02, 5'h03);
    #1;
    if (pm.late) begin
      fails++;
    end
    chk({27'h0, pm.cause}, {27'h0, cause});
    chk(pm.gpr[3], (cause != 5'h00) ? 32'h5a5a5a5a : exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, `SFPU_REG_CTRL, 32'h0);
    chk(rd_v, 32'h0);
    apb(1'b0, `SFPU_REG_STATUS, 32'h0);
    chk(rd_v, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk({rd_v[30:0], err_v}, 32'h1);
  endtask

  task automatic t_arith;
    run_op(`SFPU_OP_ADD, 32'h3fc00000, 32'h40200000, 32'h40800000, 5'h0);
    run_op(`SFPU_OP_SUB, 32'h3f800000, 32'h40400000, 32'hc0000000, 5'h0);
    run_op(`SFPU_OP_MUL, 32'h3fc00000, 32'hc0000000, 32'hc0400000, 5'h0);
    run_op(`SFPU_OP_DIV, 32'h40400000, 32'h3f000000, 32'h40c00000, 5'h0);
  endtask

  task automatic t_round;
    run_op(`SFPU_OP_ADD, 32'h3f800000, 32'h33800000, 32'h3f800000, 5'h0);
    run_op(`SFPU_OP_ADD, 32'h3f800001, 32'h33800000, 32'h3f800002, 5'h0);
    run_op(`SFPU_OP_DIV, 32'h3f800000, 32'h40400000, 32'h3eaaaaab, 5'h0);
  endtask

  task automatic t_cmp;
    logic [6:0] lo, eq, un;
    lo = 7'h15;
    eq = 7'h26;
    un = 7'h40;
    for (int i = 0; i < 7; i++) begin
      run_op(4'h8 + 4'(i), 32'h3f800000, 32'h40000000, {31'h0, lo[i]}, 5'h0);
      run_op(4'h8 + 4'(i), 32'h40000000, 32'h40000000, {31'h0, eq[i]}, 5'h0);
      run_op(4'h8 + 4'(i), 32'h7fc00000, 32'h40000000, {31'h0, un[i]}, 5'h0);
    end
  endtask

  task automatic t_special;
    run_op(`SFPU_OP_ADD, 32'hffc00001, 32'h3f800000, 32'hffc00000, 5'h0);
    run_op(`SFPU_OP_MUL, 32'h3f800000, 32'h7f800001, 32'hffc00000, 5'h0);
    run_op(`SFPU_OP_ADD, 32'h7f800000, 32'h3f800000, 32'h7f800000, 5'h0);
    run_op(`SFPU_OP_MUL, 32'hff800000, 32'h40000000, 32'hff800000, 5'h0);
    run_op(`SFPU_OP_ADD, 32'h00000001, 32'h3f800000, 32'hffc00000, 5'h0);
    run_op(`SFPU_OP_MUL, 32'h80800000, 32'h3f000000, 32'h80000000, 5'h0);
    run_op(`SFPU_OP_MUL, 32'h7f000000, 32'h40000000, 32'h7f800000, 5'h0);
    apb(1'b0, `SFPU_REG_STATUS, 32'h0);
    chk(rd_v, 32'h17);
    run_op(`SFPU_OP_ADD, 32'h3f800000, 32'h3f800000, 32'h40000000, 5'h0);
    apb(1'b0, `SFPU_REG_STATUS, 32'h0);
    chk(rd_v, 32'h17);
    apb(1'b1, `SFPU_REG_STATUS, 32'h1f);
    apb(1'b0, `SFPU_REG_STATUS, 32'h0);
    chk(rd_v, 32'h0);
  endtask

  task automatic t_trap;
    apb(1'b1, `SFPU_REG_CTRL, 32'h1f);
    apb(1'b0, `SFPU_REG_CTRL, 32'h0);
    chk(rd_v, 32'h1f);
    run_op(`SFPU_OP_MUL, 32'h7f000000, 32'h40000000, 32'h0, 5'h02);
    apb(1'b0, `SFPU_REG_RESULT, 32'h0);
    chk(rd_v, 32'h7f800000);
    run_op(`SFPU_OP_DIV, 32'h3f800000, 32'h00000000, 32'h0, 5'h08);
    run_op(`SFPU_OP_ADD, 32'h00000001, 32'h3f800000, 32'h0, 5'h10);
    run_op(`SFPU_OP_MUL, 32'h80800000, 32'h3f000000, 32'h0, 5'h01);
    run_op(`SFPU_OP_MUL, 32'h7f800000, 32'h00000000, 32'h0, 5'h04);
    apb(1'b1, `SFPU_REG_CTRL, 32'h0);
    apb(1'b1, `SFPU_REG_STATUS, 32'h1f);
  endtask

  // ----------------------------------------------------------------
  // clock, sequence and verdict
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    final_report;
  end

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_arith;
    t_round;
    t_cmp;
    t_special;
    t_trap;
    final_report;
  end
endmodule // tb_single_precision_fpu
`default_nettype wire
